// ===== design/dmd_decoder.sv
// Data memory map decoder with core access port and APB register access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module dmd_decoder
  import dmd_pkg::*;
#(
  parameter dmd_addr_t GPR_LAST = GPR_LAST_DEFAULT
)
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire dmd_core_req_s core_req,
  output dmd_core_rsp_s      core_rsp,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr
);

  localparam int GPR_WORDS = int'(GPR_LAST) + 1;

  // ==========================================================================
  // Storage
  dmd_byte_t gpr_mem  [GPR_WORDS];
  dmd_byte_t core_sfr [CORE_SFR_COUNT];

  function automatic dmd_byte_t sfr_reset(input int i);
    if (i == int'(INTERRUPT_CONTROL_SECOND_ADDR - CORE_SFR_BASE))
      return INT_CTRL_SECOND_RST;
    else if (i == int'(INTERRUPT_CONTROL_THIRD_ADDR - CORE_SFR_BASE))
      return INT_CTRL_THIRD_RST;
    else
      return SFR_RESET_DEFAULT;
  endfunction

  function automatic dmd_byte_t sfr_mask(input int i);
    if (i == int'(BANK_SELECTOR_ADDR - CORE_SFR_BASE))
      return BANK_SELECTOR_MASK;
    else if (i == int'(POINTER0_HIGH_ADDR - CORE_SFR_BASE) ||
             i == int'(POINTER1_HIGH_ADDR - CORE_SFR_BASE) ||
             i == int'(POINTER2_HIGH_ADDR - CORE_SFR_BASE))
      return POINTER_HIGH_MASK;
    else
      return FULL_MASK;
  endfunction

  // Slots 3..7 of groups 0..2 are indirect operands, not storage
  function automatic logic is_operand_slot(input logic [5:0] idx);
    return (int'(idx[5:3]) < POINTER_GROUPS) && (idx[2:0] >= SLOT_PLUS);
  endfunction

  // ==========================================================================
  // Access selection: the core always wins, APB waits in its access phase
  localparam logic [5:0] BANK_IDX =
    6'(BANK_SELECTOR_ADDR - CORE_SFR_BASE);
  localparam logic [5:0] ACCUM_IDX =
    6'(WORKING_ACCUMULATOR_ADDR - CORE_SFR_BASE);

  logic      apb_go;
  logic      apb_in_map;
  logic      acc_valid;
  logic      acc_write;
  dmd_addr_t acc_addr;
  dmd_byte_t acc_wdata;
  dmd_byte_t bank_sel;

  assign bank_sel   = core_sfr[BANK_IDX];
  assign apb_in_map = (paddr[31:APB_ADDR_TOP] == '0);
  assign apb_go     = psel & penable & ~pready & ~core_req.valid;
  assign acc_valid  = core_req.valid | (apb_go & apb_in_map);
  assign acc_write  = core_req.valid ? core_req.write : pwrite;
  assign acc_wdata  = core_req.valid ? core_req.wdata : pwdata[7:0];

  always_comb
  begin
    if (!core_req.valid)
      acc_addr = paddr[APB_ADDR_TOP-1:APB_WORD_LSB];
    else if (core_req.banked)
      acc_addr = {bank_sel[3:0], core_req.addr[7:0]};
    else
      acc_addr = core_req.addr;
  end

  // ==========================================================================
  // First level: direct location or indirect operand
  logic       first_core;
  logic [5:0] first_idx;
  logic [2:0] group;
  logic [2:0] slot;
  logic       is_ind;
  logic [5:0] ptr_lo_idx;
  logic [5:0] ptr_hi_idx;
  dmd_addr_t  ptr_val;
  dmd_byte_t  accum;

  assign first_core = (acc_addr >= CORE_SFR_BASE);
  assign first_idx  = 6'(acc_addr - CORE_SFR_BASE);
  assign group      = first_idx[5:3];
  assign slot       = first_idx[2:0];
  assign is_ind     = first_core && is_operand_slot(first_idx);
  assign ptr_lo_idx = {group, SLOT_LOW};
  assign ptr_hi_idx = {group, SLOT_HIGH};
  // Full 12-bit pointer, bank selector not involved
  assign ptr_val    = {core_sfr[ptr_hi_idx][3:0], core_sfr[ptr_lo_idx]};
  assign accum      = core_sfr[ACCUM_IDX];

  dmd_addr_t eff_addr;
  dmd_addr_t next_ptr;
  logic      ptr_upd;

  always_comb
  begin
    eff_addr = acc_addr;
    next_ptr = ptr_val;
    ptr_upd  = 1'b0;
    if (is_ind)
    begin
      unique case (slot)
        SLOT_PLUS:
          eff_addr = ptr_val + {{4{accum[7]}}, accum};
        SLOT_INC_FIRST:
        begin
          eff_addr = ptr_val + 12'h001;
          next_ptr = ptr_val + 12'h001;
          ptr_upd  = acc_valid;
        end
        SLOT_DEC_AFTER:
        begin
          eff_addr = ptr_val;
          next_ptr = ptr_val - 12'h001;
          ptr_upd  = acc_valid;
        end
        SLOT_INC_AFTER:
        begin
          eff_addr = ptr_val;
          next_ptr = ptr_val + 12'h001;
          ptr_upd  = acc_valid;
        end
        SLOT_PLAIN:
          eff_addr = ptr_val;
        default:
          eff_addr = ptr_val;
      endcase
    end
  end

  // ==========================================================================
  // Second level: final target of the effective address
  logic        eff_core;
  logic [5:0]  eff_idx;
  logic        hit_gpr;
  logic        hit_sfr;
  dmd_target_e target;
  dmd_byte_t   rd_val;

  assign eff_core = (eff_addr >= CORE_SFR_BASE);
  assign eff_idx  = 6'(eff_addr - CORE_SFR_BASE);
  // Pointer through an operand address lands nowhere: reads zero
  // Ram starts at address zero, so only the upper bound is tested
  assign hit_gpr  = (eff_addr <= GPR_LAST) &&
                    (eff_addr < SFR_AREA_BASE);
  assign hit_sfr  = eff_core && !is_operand_slot(eff_idx);

  always_comb
  begin
    if (is_ind)
      target = TGT_INDIRECT;
    else if (hit_gpr)
      target = TGT_GPR;
    else if (hit_sfr)
      target = TGT_SFR;
    else
      target = TGT_NONE;
  end

  always_comb
  begin
    rd_val = '0;
    if (hit_gpr)
      rd_val = gpr_mem[eff_addr];
    else if (hit_sfr)
      rd_val = core_sfr[eff_idx];
    else
      rd_val = '0;
  end

  // ==========================================================================
  // General RAM: no reset at all, so every reset keeps its contents
  always_ff @(posedge clk)
  begin
    if (acc_valid && acc_write && hit_gpr)
      gpr_mem[eff_addr] <= acc_wdata;
  end

  // ==========================================================================
  // Core special function storage, one flop byte per location
  for (genvar i = 0; i < CORE_SFR_COUNT; i++)
  begin : g_sfr
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        core_sfr[i] <= sfr_reset(i);
      // Pointer side effect beats a write landing on the same pointer
      else if (ptr_upd && ptr_lo_idx == 6'(i))
        core_sfr[i] <= next_ptr[7:0];
      else if (ptr_upd && ptr_hi_idx == 6'(i))
        core_sfr[i] <= {4'h0, next_ptr[11:8]};
      else if (acc_valid && acc_write && hit_sfr && eff_idx == 6'(i))
        core_sfr[i] <= acc_wdata & sfr_mask(i);
    end
  end

  // ==========================================================================
  // Core answer, one cycle after each request
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_rsp.ack      <= 1'b0;
      core_rsp.target   <= TGT_NONE;
      core_rsp.eff_addr <= '0;
      core_rsp.rdata    <= '0;
    end
    else
    begin
      core_rsp.ack <= core_req.valid;
      if (core_req.valid)
      begin
        core_rsp.target   <= target;
        core_rsp.eff_addr <= eff_addr;
        core_rsp.rdata    <= rd_val;
      end
    end
  end

  // ==========================================================================
  // APB answer, pready a single cycle after the served access phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_go;
      pslverr <= apb_go & ~apb_in_map;
      if (apb_go)
        prdata <= {24'h00_0000, apb_in_map ? rd_val : 8'h00};
    end
  end

endmodule

// ===== design/dmd_pkg.sv
// Constants, types and register map of the data memory map decoder
package dmd_pkg;

  // ==========================================================================
  // Widths and address space
  localparam int ADDR_W         = 12;
  localparam int DATA_W         = 8;
  localparam int CORE_SFR_COUNT = 40;
  localparam int POINTER_GROUPS = 3;
  localparam int APB_WORD_LSB   = 2;
  localparam int APB_ADDR_TOP   = 14;

  typedef logic [ADDR_W-1:0] dmd_addr_t;
  typedef logic [DATA_W-1:0] dmd_byte_t;

  localparam dmd_addr_t GPR_BASE         = 12'h000;
  localparam dmd_addr_t GPR_LAST_DEFAULT = 12'hf5f;
  localparam dmd_addr_t SFR_AREA_BASE    = 12'hf60;
  localparam dmd_addr_t SFR_AREA_LAST    = 12'hfff;

  // ==========================================================================
  // Core register addresses
  localparam dmd_addr_t ALU_CONDITION_FLAGS_ADDR        = 12'hfd8;
  localparam dmd_addr_t POINTER2_LOW_ADDR               = 12'hfd9;
  localparam dmd_addr_t POINTER2_HIGH_ADDR              = 12'hfda;
  localparam dmd_addr_t POINTER2_PLUS_ACCUMULATOR_ADDR  = 12'hfdb;
  localparam dmd_addr_t POINTER2_PRE_INCREMENT_ADDR     = 12'hfdc;
  localparam dmd_addr_t POINTER2_POST_DECREMENT_ADDR    = 12'hfdd;
  localparam dmd_addr_t POINTER2_POST_INCREMENT_ADDR    = 12'hfde;
  localparam dmd_addr_t POINTER2_INDIRECT_ADDR          = 12'hfdf;
  localparam dmd_addr_t BANK_SELECTOR_ADDR              = 12'hfe0;
  localparam dmd_addr_t POINTER1_LOW_ADDR               = 12'hfe1;
  localparam dmd_addr_t POINTER1_HIGH_ADDR              = 12'hfe2;
  localparam dmd_addr_t POINTER1_PLUS_ACCUMULATOR_ADDR  = 12'hfe3;
  localparam dmd_addr_t POINTER1_PRE_INCREMENT_ADDR     = 12'hfe4;
  localparam dmd_addr_t POINTER1_POST_DECREMENT_ADDR    = 12'hfe5;
  localparam dmd_addr_t POINTER1_POST_INCREMENT_ADDR    = 12'hfe6;
  localparam dmd_addr_t POINTER1_INDIRECT_ADDR          = 12'hfe7;
  localparam dmd_addr_t WORKING_ACCUMULATOR_ADDR        = 12'hfe8;
  localparam dmd_addr_t POINTER0_LOW_ADDR               = 12'hfe9;
  localparam dmd_addr_t POINTER0_HIGH_ADDR              = 12'hfea;
  localparam dmd_addr_t POINTER0_PLUS_ACCUMULATOR_ADDR  = 12'hfeb;
  localparam dmd_addr_t POINTER0_PRE_INCREMENT_ADDR     = 12'hfec;
  localparam dmd_addr_t POINTER0_POST_DECREMENT_ADDR    = 12'hfed;
  localparam dmd_addr_t POINTER0_POST_INCREMENT_ADDR    = 12'hfee;
  localparam dmd_addr_t POINTER0_INDIRECT_ADDR          = 12'hfef;
  localparam dmd_addr_t INTERRUPT_CONTROL_THIRD_ADDR    = 12'hff0;
  localparam dmd_addr_t INTERRUPT_CONTROL_SECOND_ADDR   = 12'hff1;
  localparam dmd_addr_t INTERRUPT_CONTROL_FIRST_ADDR    = 12'hff2;
  localparam dmd_addr_t MULTIPLY_RESULT_LOW_ADDR        = 12'hff3;
  localparam dmd_addr_t MULTIPLY_RESULT_HIGH_ADDR       = 12'hff4;
  localparam dmd_addr_t PROGRAM_TABLE_LATCH_ADDR        = 12'hff5;
  localparam dmd_addr_t PROGRAM_TABLE_PTR_LOW_ADDR      = 12'hff6;
  localparam dmd_addr_t PROGRAM_TABLE_PTR_HIGH_ADDR     = 12'hff7;
  localparam dmd_addr_t PROGRAM_TABLE_PTR_UPPER_ADDR    = 12'hff8;
  localparam dmd_addr_t PROGRAM_COUNTER_LOW_ADDR        = 12'hff9;
  localparam dmd_addr_t PROGRAM_COUNTER_HOLD_HIGH_ADDR  = 12'hffa;
  localparam dmd_addr_t PROGRAM_COUNTER_HOLD_UPPER_ADDR = 12'hffb;
  localparam dmd_addr_t RETURN_STACK_POINTER_ADDR       = 12'hffc;
  localparam dmd_addr_t STACK_TOP_LOW_ADDR              = 12'hffd;
  localparam dmd_addr_t STACK_TOP_HIGH_ADDR             = 12'hffe;
  localparam dmd_addr_t STACK_TOP_UPPER_ADDR            = 12'hfff;

  localparam dmd_addr_t CORE_SFR_BASE = ALU_CONDITION_FLAGS_ADDR;

  // ==========================================================================
  // Reset values and implemented bits
  localparam dmd_byte_t SFR_RESET_DEFAULT    = 8'h00;
  localparam dmd_byte_t INT_CTRL_SECOND_RST  = 8'hff;
  localparam dmd_byte_t INT_CTRL_THIRD_RST   = 8'hc0;
  localparam dmd_byte_t FULL_MASK            = 8'hff;
  localparam dmd_byte_t BANK_SELECTOR_MASK   = 8'h0f;
  localparam dmd_byte_t POINTER_HIGH_MASK    = 8'h0f;

  // ==========================================================================
  // Slot layout inside one pointer group of eight addresses
  localparam logic [2:0] SLOT_LOW       = 3'h1;
  localparam logic [2:0] SLOT_HIGH      = 3'h2;
  localparam logic [2:0] SLOT_PLUS      = 3'h3;
  localparam logic [2:0] SLOT_INC_FIRST = 3'h4;
  localparam logic [2:0] SLOT_DEC_AFTER = 3'h5;
  localparam logic [2:0] SLOT_INC_AFTER = 3'h6;
  localparam logic [2:0] SLOT_PLAIN     = 3'h7;

  typedef enum logic [3:0] {
    TGT_GPR      = 4'b0001,
    TGT_SFR      = 4'b0010,
    TGT_INDIRECT = 4'b0100,
    TGT_NONE     = 4'b1000
  } dmd_target_e;

  typedef struct packed {
    logic      valid;
    logic      write;
    logic      banked;
    dmd_addr_t addr;
    dmd_byte_t wdata;
  } dmd_core_req_s;

  typedef struct packed {
    logic        ack;
    dmd_target_e target;
    dmd_addr_t   eff_addr;
    dmd_byte_t   rdata;
  } dmd_core_rsp_s;

endpackage

// ===== tb/dmd_decoder_assertions.sv
// Port checker for the data memory map decoder
`timescale 1ns/100ps
module dmd_decoder_assertions
  import dmd_pkg::*;
#(
  parameter dmd_addr_t GPR_LAST = GPR_LAST_DEFAULT
)
(
  input wire logic          clk,
  input wire logic          nrst,
  input wire dmd_core_req_s core_req,
  input wire dmd_core_rsp_s core_rsp,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr
);
  // ==========
  // Helpers
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire dmd_addr_t  a   = core_req.addr;
  wire logic [7:0] lo  = core_req.addr[7:0];
  wire logic       dir = core_req.valid && !core_req.banked;
  wire logic       tkn = psel && penable && !pready && !core_req.valid;

  // ==========
  // Properties
  chk_ack_follows: assert property (
    core_req.valid |=> core_rsp.ack) else $error("missing ack");
  chk_ack_alone: assert property (
    !core_req.valid |=> !core_rsp.ack) else $error("stray ack");
  chk_gpr_map: assert property (
    dir && a <= GPR_LAST |=> core_rsp.target == TGT_GPR
    && core_rsp.eff_addr == $past(a)) else $error("ram decode");
  chk_gap_zero: assert property (
    dir && !core_req.write && a > GPR_LAST && a < 12'hfd8
    |=> core_rsp.target == TGT_NONE && core_rsp.rdata == 8'h00)
    else $error("gap decode");
  chk_indirect_slot: assert property (
    dir && a inside {[12'hfd8:12'hfef]} && a[2:0] > 3'h2
    |=> core_rsp.target == TGT_INDIRECT) else $error("indirect decode");
  chk_core_reg: assert property (
    dir && a >= 12'hfd8 && (a >= 12'hff0 || a[2:0] < 3'h3)
    |=> core_rsp.target == TGT_SFR && core_rsp.eff_addr == $past(a))
    else $error("core register decode");
  chk_bank_form: assert property (
    core_req.valid && core_req.banked && lo < 8'h60
    |=> core_rsp.target == TGT_GPR && core_rsp.eff_addr[7:0] == $past(lo))
    else $error("banked decode");
  chk_apb_answer: assert property (
    tkn |=> pready) else $error("no apb answer");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("long ready");
  chk_err_zero: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("error data");

  cover property (dir && a <= GPR_LAST ##1 core_rsp.ack);
  cover property (core_rsp.ack && core_rsp.target == TGT_INDIRECT);
  cover property (pready && pslverr);
endmodule

bind dmd_decoder dmd_decoder_assertions #(.GPR_LAST(GPR_LAST)) chk (
  .clk(clk), .nrst(nrst), .core_req(core_req), .core_rsp(core_rsp),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== tb/dmd_core_model.sv
// Core datapath model issuing data memory accesses
`timescale 1ns/100ps
module dmd_core_model
  import dmd_pkg::*;
(
  input  wire logic     clk,
  output dmd_core_req_s core_req
);
  // ==========
  // Access tasks, entered just after a rising edge
  initial core_req = '0;

  task automatic acc(input logic w, b, input dmd_addr_t a,
                     input dmd_byte_t d);
    core_req <= '{1'b1, w, b, a, d};
    @(posedge clk);
  endtask

  // Idle lines flip so a stale address never passes for a live one
  task automatic idle(input int n);
    core_req <= '{1'b0, 1'b0, 1'b0, ~core_req.addr, ~core_req.wdata};
    repeat (n) @(posedge clk);
  endtask
endmodule

// ===== tb/data_memory_map_decoder_test.sv
// Self-checking bench for the data memory map decoder
`timescale 1ns/100ps
module data_memory_map_decoder_test
  import dmd_pkg::*;
;
  logic          clk = 0;
  logic          nrst = 0;
  logic          psel = 0;
  logic          penable = 0;
  logic          pwrite = 0;
  logic [31:0]   paddr = '0;
  logic [31:0]   pwdata = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  dmd_core_req_s req;
  dmd_core_rsp_s rsp;
  dmd_core_rsp_s e;
  dmd_core_rsp_s qe[$];
  bit            qr[$];
  logic [32:0]   qa[$];
  dmd_byte_t     mem[dmd_addr_t];
  dmd_addr_t     a;
  dmd_byte_t     v;
  int            failures = 0;
  int            checked = 0;
  int            cyc = 0;
  int            seed = 32'hebfc;
  dmd_addr_t     slot[5] = '{12'hfef, 12'hfee, 12'hfed, 12'hfec, 12'hfeb};
  dmd_addr_t     eff[5] = '{12'h200, 12'h200, 12'h201, 12'h201, 12'h206};

  always #5 clk = ~clk;

  dmd_decoder DUT (.clk(clk), .nrst(nrst), .core_req(req), .core_rsp(rsp),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dmd_core_model core (.clk(clk), .core_req(req));

  // ==========
  // Tasks
  function automatic logic [31:0] pa(input dmd_addr_t x);
    return {18'h0, x, 2'b00};
  endfunction

  task automatic check(input logic [32:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] ad, d);
    core.idle(1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ar(input logic [31:0] ad, input logic [32:0] x);
    qa.push_back(x);
    apb(1'b0, ad, 32'h0);
  endtask

  // Read data doubles as the expected value; writes skip it
  task automatic cx(input logic w, b, input dmd_addr_t ad,
                    input dmd_byte_t d, input dmd_target_e t,
                    input dmd_addr_t ea);
    qe.push_back('{1'b1, t, ea, d});
    qr.push_back(!w);
    core.acc(w, b, ad, d);
  endtask

  // ==========
  // Monitors and timeout
  always @(negedge clk)
    if (rsp.ack === 1'b1)
    begin
      e = qe.pop_front();
      check({rsp.target, rsp.eff_addr}, {e.target, e.eff_addr});
      if (qr.pop_front())
        check(rsp.rdata, e.rdata);
    end

  // Read data taken at the edge that samples pready high
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, qa.pop_front());

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      print_verdict();
    end
  end

  // ==========
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    ar(pa(12'hf5e), {25'h0, 8'hxx});
    ar(pa(INTERRUPT_CONTROL_SECOND_ADDR), 33'h0ff);
    ar(pa(INTERRUPT_CONTROL_THIRD_ADDR), 33'h0c0);
    apb(1'b1, pa(BANK_SELECTOR_ADDR), 32'hffff_ffff);
    ar(pa(BANK_SELECTOR_ADDR), 33'h00f);
    ar(32'h0004_0000, {1'b1, 32'h0});
    apb(1'b1, pa(12'hf60), 32'h0000_00a5);
    ar(pa(12'hf60), 33'h0);
    for (int i = 0; i < 2; i++)
    begin
      a = i ? 12'hfd7 : 12'hf60;
      cx(1'b1, 1'b0, a, 8'h5a, TGT_NONE, a);
      cx(1'b0, 1'b0, a, 8'h00, TGT_NONE, a);
    end
    cx(1'b1, 1'b0, 12'hfe8, 8'h05, TGT_SFR, 12'hfe8);
    repeat (6)
    begin
      a = dmd_addr_t'($unsigned($random(seed)) % 32'h0000_0f60);
      v = dmd_byte_t'($random(seed));
      cx(1'b1, 1'b0, a, v, TGT_GPR, a);
      ar(pa(a), {25'h0, v});
      apb(1'b1, pa(a), {24'h0, ~v});
      mem[a] = ~v;
      cx(1'b0, 1'b0, a, ~v, TGT_GPR, a);
    end
    cx(1'b1, 1'b0, 12'hfe0, 8'h03, TGT_SFR, 12'hfe0);
    cx(1'b1, 1'b1, 12'h045, 8'h3c, TGT_GPR, 12'h345);
    mem[12'h345] = 8'h3c;
    cx(1'b1, 1'b0, 12'hfe9, 8'h00, TGT_SFR, 12'hfe9);
    cx(1'b1, 1'b0, 12'hfea, 8'h02, TGT_SFR, 12'hfea);
    for (int i = 0; i < 5; i++)
    begin
      v = dmd_byte_t'(i) + 8'h10;
      cx(1'b1, 1'b0, slot[i], v, TGT_INDIRECT, eff[i]);
      mem[eff[i]] = v;
    end
    cx(1'b0, 1'b0, 12'hfe9, 8'h01, TGT_SFR, 12'hfe9);
    core.idle(1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ar(pa(BANK_SELECTOR_ADDR), 33'h0);
    foreach (mem[k])
      cx(1'b0, 1'b0, k, mem[k], TGT_GPR, k);
    core.idle(3);
    print_verdict();
  end
endmodule
